// *** pkg/sbst_cfg.svh ***
`ifndef SBST_CFG_SVH
`define SBST_CFG_SVH

// ****************************************
// Register sizes
// ****************************************
`define SBST_IR_W 3
`define SBST_ID_W 32
`define SBST_BSR_LEN 109
`define SBST_OE_CELL 108
`define SBST_PIN_CNT 108

// ****************************************
// Instruction codes
// ****************************************
`define SBST_OP_EXTEST 3'h0
`define SBST_OP_IDREAD 3'h1
`define SBST_OP_SAMPZ 3'h2
`define SBST_OP_RSV0 3'h3
`define SBST_OP_SAMPLE 3'h4
`define SBST_OP_RSV1 3'h5
`define SBST_OP_RSV2 3'h6
`define SBST_OP_BYPASS 3'h7
`define SBST_IR_CAPT 3'h1

// ****************************************
// Identification word layout
// ****************************************
`define SBST_ID_REV_HI 31
`define SBST_ID_REV_LO 29
`define SBST_ID_PART_HI 28
`define SBST_ID_PART_LO 12
`define SBST_ID_MFR_HI 11
`define SBST_ID_MFR_LO 1
`define SBST_ID_PRES_BIT 0
`define SBST_ID_PRES 1'h1

// ****************************************
// Timing
// ****************************************
`define SBST_TLR_HOLD 5
`define SBST_SYNC_STAGES 2

`endif

// *** pkg/sbst_pkg.sv ***
package sbst_pkg;
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } sbst_state_t;
  typedef logic [2:0] sbst_ir_t;
endpackage

// *** hw/sbst_fsm.sv ***
`include "sbst_cfg.svh"

module sbst_fsm import sbst_pkg::*; (
  input wire logic tck_i,
  input wire logic trstn_i,
  input wire logic tms_i,
  output sbst_state_t state_o
);
  sbst_state_t state_reg;
  sbst_state_t state_next;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin // [RL2]
    case (state_reg)
      ST_TLR: state_next = tms_i ? ST_TLR : ST_RTI;
      ST_RTI: state_next = tms_i ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_next = tms_i ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms_i ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: state_next = tms_i ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_next = tms_i ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR: state_next = tms_i ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: state_next = tms_i ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_next = tms_i ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_next = tms_i ? ST_TLR : ST_CAP_IR; // [RL17]
      ST_CAP_IR: state_next = tms_i ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: state_next = tms_i ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_next = tms_i ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR: state_next = tms_i ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: state_next = tms_i ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_next = tms_i ? ST_SEL_DR : ST_RTI;
      default: state_next = ST_TLR;
    endcase
  end

  // Mode select is taken as is on each rising test clock edge
  always_ff @(posedge tck_i or negedge trstn_i) begin // [RL1]
    if (!trstn_i) begin
      state_reg <= ST_TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state_o = state_reg;

  // ****************************************
  // Checks
  // ****************************************
  five_ones_a: assert property (@(posedge tck_i) disable iff (!trstn_i) // [RL17]
    tms_i [*5] |=> state_reg == ST_TLR)
    else $error("five high mode-select edges did not reach reset state");
  upd_dr_a: assert property (@(posedge tck_i) disable iff (!trstn_i) // [RL2]
    state_reg == ST_UPD_DR |=> state_reg inside {ST_SEL_DR, ST_RTI})
    else $error("bad exit from data update state");
  shift_stay_a: assert property (@(posedge tck_i) disable iff (!trstn_i) // [RL1]
    (state_reg == ST_SH_IR && !tms_i) |=> state_reg == ST_SH_IR)
    else $error("instruction shift left with mode-select low");
endmodule // sbst_fsm

// *** hw/sbst_tap.sv ***
`include "sbst_cfg.svh"

// Summary of operation
// RL1 - State machine advances on mode-select sampled at each rising test clock edge.
// RL2 - Standard sixteen-state test controller with data and instruction paths.
// RL3 - Identification bits 31:29 hold a three-bit revision.
// RL4 - Identification bits 28:12 hold the part type code.
// RL5 - Identification bits 11:1 hold the manufacturer code.
// RL6 - Identification bit 0 is always one.
// RL7 - Code 000 is external test: boundary cells drive the pins.
// RL8 - Code 001 loads and connects the identification register.
// RL9 - Code 010 samples, connects boundary chain and floats memory outputs.
// RL10 - Codes 011, 101 and 110 load like any other code and select the bypass register.
// RL11 - Code 100 samples pins into the boundary chain without disturbing memory.
// RL12 - Code 111 connects the one-bit bypass register.
// RL13 - Boundary chain is 109 cells, shifted from data-in toward data-out.
// RL14 - Serial output changes only on the falling test clock edge.
// RL15 - Instruction capture loads 01 into the two low bits.
// RL16 - Reset and test-logic-reset load the identification instruction.
// RL17 - Five rising edges with mode-select high reset the controller.
// RL18 - Cell 108 enables outputs in external test; preset to one on reset.
module sbst_tap import sbst_pkg::*; #(
  // Identification values are arbitrary
  parameter logic [2:0] REV_ID = 3'h2,
  parameter logic [16:0] PART_ID = 17'h0a5c3,
  parameter logic [10:0] MFR_ID = 11'h155,
  parameter int BSR_LEN = `SBST_BSR_LEN,
  parameter int PIN_CNT = `SBST_PIN_CNT
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic [PIN_CNT-1:0] ring_i,
  output logic tdo_o,
  output logic tdo_en_n_o,
  output logic q_float_o,
  output logic ext_drive_o,
  output logic [PIN_CNT-1:0] ext_data_o
);
  localparam logic [`SBST_ID_W-1:0] ID_WORD = {REV_ID, PART_ID, MFR_ID, `SBST_ID_PRES};

  // ****************************************
  // Test clock domain reset
  // ****************************************
  // Assert at once, release on the test clock so no state flop sees a runt
  logic [1:0] trst_sync_reg;
  logic trstn;
  always_ff @(posedge tck_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trst_sync_reg <= 2'h0;
    end else begin
      trst_sync_reg <= {trst_sync_reg[0], 1'h1};
    end
  end
  assign trstn = trst_sync_reg[1];

  sbst_state_t state;
  sbst_fsm u_fsm (
    .tck_i(tck_i),
    .trstn_i(trstn),
    .tms_i(tms_i),
    .state_o(state)
  );

  // ****************************************
  // Pin ring sampling
  // ****************************************
  // Ring pins toggle on the fast memory clock; capture is best effort
  logic [PIN_CNT-1:0] ring_s1_reg;
  logic [PIN_CNT-1:0] ring_s2_reg;
  always_ff @(posedge tck_i or negedge trstn) begin
    if (!trstn) begin
      ring_s1_reg <= '0;
      ring_s2_reg <= '0;
    end else begin
      ring_s1_reg <= ring_i;
      ring_s2_reg <= ring_s1_reg;
    end
  end

  // ****************************************
  // Instruction and data registers
  // ****************************************
  sbst_ir_t ir_reg, ir_next;
  sbst_ir_t ir_sh_reg, ir_sh_next;
  logic byp_reg, byp_next;
  logic [`SBST_ID_W-1:0] id_sh_reg, id_sh_next;
  logic [BSR_LEN-1:0] bsr_sh_reg, bsr_sh_next;
  logic [BSR_LEN-1:0] bsr_upd_reg, bsr_upd_next;
  logic upd_tgl_reg, upd_tgl_next;
  logic sel_bsr, sel_id;

  // Reserved codes fall back to the bypass path to keep the chain length sane
  assign sel_bsr = ir_reg inside {`SBST_OP_EXTEST, `SBST_OP_SAMPZ, `SBST_OP_SAMPLE};
  assign sel_id = (ir_reg == `SBST_OP_IDREAD); // [RL8]

  always_comb begin
    ir_next = ir_reg;
    ir_sh_next = ir_sh_reg;
    byp_next = byp_reg;
    id_sh_next = id_sh_reg;
    bsr_sh_next = bsr_sh_reg;
    bsr_upd_next = bsr_upd_reg;
    upd_tgl_next = upd_tgl_reg;
    case (state)
      ST_TLR: begin
        ir_next = `SBST_OP_IDREAD; // [RL16]
        if (!bsr_upd_reg[`SBST_OE_CELL]) begin
          bsr_upd_next[`SBST_OE_CELL] = 1'h1; // [RL18]
          upd_tgl_next = ~upd_tgl_reg;
        end
      end
      ST_CAP_IR: ir_sh_next = `SBST_IR_CAPT; // [RL15]
      ST_SH_IR: ir_sh_next = {tdi_i, ir_sh_reg[`SBST_IR_W-1:1]};
      ST_UPD_IR: ir_next = ir_sh_reg;
      ST_CAP_DR: begin
        if (sel_bsr) begin
          // Cell 108 has no pin; it recaptures its own latched value
          bsr_sh_next = {bsr_upd_reg[`SBST_OE_CELL], ring_s2_reg}; // [RL7] [RL9] [RL11]
        end else if (sel_id) begin
          id_sh_next = ID_WORD; // [RL3] [RL4] [RL5] [RL6] [RL8]
        end else begin
          byp_next = 1'h0; // [RL12]
        end
      end
      ST_SH_DR: begin
        if (sel_bsr) begin
          bsr_sh_next = {tdi_i, bsr_sh_reg[BSR_LEN-1:1]}; // [RL13]
        end else if (sel_id) begin
          id_sh_next = {tdi_i, id_sh_reg[`SBST_ID_W-1:1]};
        end else begin
          byp_next = tdi_i; // [RL12]
        end
      end
      ST_UPD_DR: begin
        if (sel_bsr) begin
          bsr_upd_next = bsr_sh_reg;
          upd_tgl_next = ~upd_tgl_reg;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge tck_i or negedge trstn) begin
    if (!trstn) begin
      ir_reg <= `SBST_OP_IDREAD; // [RL16]
      ir_sh_reg <= `SBST_IR_CAPT;
      byp_reg <= 1'h0;
      id_sh_reg <= '0;
      bsr_sh_reg <= '0;
      bsr_upd_reg <= {1'h1, {PIN_CNT{1'h0}}}; // [RL18]
      upd_tgl_reg <= 1'h0;
    end else begin
      ir_reg <= ir_next;
      ir_sh_reg <= ir_sh_next;
      byp_reg <= byp_next;
      id_sh_reg <= id_sh_next;
      bsr_sh_reg <= bsr_sh_next;
      bsr_upd_reg <= bsr_upd_next;
      upd_tgl_reg <= upd_tgl_next;
    end
  end

  // ****************************************
  // Serial output
  // ****************************************
  logic tdo_reg, tdo_next;
  logic tdo_en_n_reg, tdo_en_n_next;

  always_comb begin
    tdo_next = tdo_reg;
    tdo_en_n_next = 1'h1;
    if (state == ST_SH_IR) begin
      tdo_next = ir_sh_reg[0];
      tdo_en_n_next = 1'h0;
    end else if (state == ST_SH_DR) begin
      tdo_en_n_next = 1'h0;
      if (sel_bsr) begin
        tdo_next = bsr_sh_reg[0];
      end else if (sel_id) begin
        tdo_next = id_sh_reg[0];
      end else begin
        tdo_next = byp_reg;
      end
    end
  end

  // Falling edge gives the controller half a period of setup
  always_ff @(negedge tck_i or negedge trstn) begin // [RL14]
    if (!trstn) begin
      tdo_reg <= 1'h0;
      tdo_en_n_reg <= 1'h1;
    end else begin
      tdo_reg <= tdo_next;
      tdo_en_n_reg <= tdo_en_n_next;
    end
  end

  assign tdo_o = tdo_reg;
  assign tdo_en_n_o = tdo_en_n_reg;

  // ****************************************
  // Crossing to the memory clock
  // ****************************************
  // Mode levels and the update toggle pass two flops; the latched cells
  // are only read after the toggle arrives, so they are stable by then
  logic mode_ext, mode_hz;
  assign mode_ext = (ir_reg == `SBST_OP_EXTEST); // [RL7]
  assign mode_hz = (ir_reg == `SBST_OP_SAMPZ); // [RL9]

  logic [2:0] sy1_reg, sy1_next;
  logic [2:0] sy2_reg, sy2_next;
  logic tgl_d_reg, tgl_d_next;
  logic q_float_reg, q_float_next;
  logic ext_drive_reg, ext_drive_next;
  logic oe_cell_reg, oe_cell_next;
  logic [PIN_CNT-1:0] ext_data_reg, ext_data_next;

  always_comb begin
    sy1_next = sy1_reg;
    sy2_next = sy2_reg;
    tgl_d_next = tgl_d_reg;
    q_float_next = q_float_reg;
    ext_drive_next = ext_drive_reg;
    oe_cell_next = oe_cell_reg;
    ext_data_next = ext_data_reg;
    if (ce_i) begin
      sy1_next = {upd_tgl_reg, mode_hz, mode_ext};
      sy2_next = sy1_reg;
      tgl_d_next = sy2_reg[2];
      if (sy2_reg[2] != tgl_d_reg) begin
        oe_cell_next = bsr_upd_reg[`SBST_OE_CELL];
        ext_data_next = bsr_upd_reg[PIN_CNT-1:0];
      end
      ext_drive_next = sy2_reg[0]; // [RL7]
      // Float on sample-z, or in external test when cell 108 is low
      q_float_next = sy2_reg[1] | (sy2_reg[0] & ~oe_cell_reg); // [RL9] [RL18]
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sy1_reg <= 3'h0;
      sy2_reg <= 3'h0;
      tgl_d_reg <= 1'h0;
      q_float_reg <= 1'h0;
      ext_drive_reg <= 1'h0;
      oe_cell_reg <= 1'h1;
      ext_data_reg <= '0;
    end else begin
      sy1_reg <= sy1_next;
      sy2_reg <= sy2_next;
      tgl_d_reg <= tgl_d_next;
      q_float_reg <= q_float_next;
      ext_drive_reg <= ext_drive_next;
      oe_cell_reg <= oe_cell_next;
      ext_data_reg <= ext_data_next;
    end
  end

  assign q_float_o = q_float_reg;
  assign ext_drive_o = ext_drive_reg;
  assign ext_data_o = ext_data_reg;

  // ****************************************
  // Checks
  // ****************************************
  ir_capture_a: assert property (@(posedge tck_i) disable iff (!trstn) // [RL15]
    state == ST_CAP_IR |=> ir_sh_reg[1:0] == 2'h1)
    else $error("instruction capture pattern wrong");
  ir_reset_a: assert property (@(posedge tck_i) disable iff (!trstn) // [RL16]
    state == ST_TLR |=> ir_reg == `SBST_OP_IDREAD)
    else $error("reset state did not load identification instruction");
  id_fields_a: assert property (@(posedge tck_i) disable iff (!trstn) // [RL4]
    (state == ST_CAP_DR && sel_id) |=>
      id_sh_reg[`SBST_ID_PART_HI:`SBST_ID_PART_LO] == PART_ID
      && id_sh_reg[`SBST_ID_REV_HI:`SBST_ID_REV_LO] == REV_ID
      && id_sh_reg[`SBST_ID_MFR_HI:`SBST_ID_MFR_LO] == MFR_ID)
    else $error("identification fields wrong after capture");
  id_present_a: assert property (@(posedge tck_i) disable iff (!trstn) // [RL6]
    (state == ST_CAP_DR && sel_id) ##1 (state == ST_SH_DR) |-> tdo_next == 1'h1)
    else $error("identification presence bit not first out");
  bsr_shift_a: assert property (@(posedge tck_i) disable iff (!trstn) // [RL13]
    (state == ST_SH_DR && sel_bsr) |=>
      bsr_sh_reg == {$past(tdi_i), $past(bsr_sh_reg[BSR_LEN-1:1])})
    else $error("boundary chain shift wrong");
  byp_shift_a: assert property (@(posedge tck_i) disable iff (!trstn) // [RL12]
    (state == ST_SH_DR && ir_reg == `SBST_OP_BYPASS) |=> byp_reg == $past(tdi_i))
    else $error("bypass bit did not take serial input");
  tdo_fall_a: assert property (@(negedge tck_i) disable iff (!trstn) // [RL14]
    state == ST_SH_IR |=> (tdo_reg == $past(ir_sh_reg[0]) && !tdo_en_n_reg))
    else $error("serial output not updated on falling edge");
  tdo_idle_a: assert property (@(negedge tck_i) disable iff (!trstn) // [RL14]
    state == ST_RTI |=> tdo_en_n_reg)
    else $error("serial output driven outside shift");
  oe_preset_a: assert property (@(posedge tck_i) disable iff (!trstn) // [RL18]
    state == ST_TLR |=> bsr_upd_reg[`SBST_OE_CELL])
    else $error("output enable cell not preset");
  hz_float_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RL9]
    (ce_i && sy2_reg[1]) |=> q_float_reg)
    else $error("memory outputs not floated on sample-z");

  id_read_c: cover property (@(posedge tck_i) disable iff (!trstn)
    state == ST_SH_DR && sel_id);
  ir_load_c: cover property (@(posedge tck_i) disable iff (!trstn)
    state == ST_UPD_IR && ir_sh_reg == `SBST_OP_EXTEST);
  ext_float_c: cover property (@(posedge clk_i) disable iff (!rstn_i)
    ext_drive_reg && q_float_reg);
  byp_c: cover property (@(posedge tck_i) disable iff (!trstn)
    state == ST_SH_DR && ir_reg == `SBST_OP_BYPASS);
endmodule // sbst_tap

// *** tb/sbst_jtag_host.sv ***
// ****************************************
// Test controller model: test clock runs only inside frames
// ****************************************
module sbst_jtag_host (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // Levels set while the clock is low and held over the rising edge
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #7.5 tck_o = 1'b1;
    tdo = tdo_i;
    #7.5 tck_o = 1'b0;
  endtask

  task automatic tap_reset();
    logic t;
    repeat (5) step(1'b1, tdi_o, t);
    step(1'b0, tdi_o, t);
  endtask

  // From run-test/idle through one shift back to run-test/idle
  task automatic shift(input logic is_ir, input int n, input logic [127:0] din,
                       output logic [127:0] dout);
    logic t;
    dout = '0;
    step(1'b1, tdi_o, t);
    if (is_ir) step(1'b1, tdi_o, t);
    step(1'b0, tdi_o, t);
    step(1'b0, tdi_o, t);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    // Released data line must not keep showing the last bit
    step(1'b1, ~din[n-1], t);
    step(1'b0, ~din[n-1], t);
  endtask
endmodule // sbst_jtag_host

// *** tb/testbench.sv ***
`include "sbst_cfg.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  // Identification values are arbitrary
  localparam logic [2:0] REV = 3'h5;
  localparam logic [16:0] PART = 17'h1b2c4;
  localparam logic [10:0] MFR = 11'h2aa;
  localparam int LEN = `SBST_BSR_LEN;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [107:0] ring = '0;
  logic tck, tms, tdi, tdo, tdo_en_n, q_float, ext_drive;
  logic [107:0] ext_data;
  logic [31:0] seed = 32'h0000000a;
  logic [127:0] din, dout, latch;
  logic oe = 1'b1;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  sbst_jtag_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));

  sbst_tap #(.REV_ID(REV), .PART_ID(PART), .MFR_ID(MFR)) dut (
    .clk_i(clk), .rstn_i(rstn), .ce_i(ce), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .ring_i(ring), .tdo_o(tdo), .tdo_en_n_o(tdo_en_n), .q_float_o(q_float),
    .ext_drive_o(ext_drive), .ext_data_o(ext_data));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic load_ir(input logic [2:0] code);
    host.shift(1'b1, 3, 128'(code), dout);
    check("ir capture", 128'h1, 128'(dout[1:0]));
  endtask

  task automatic scan(input int n, input logic top);
    din = {rnd(), rnd(), rnd(), rnd()};
    din[108] = top;
    host.shift(1'b0, n, din, dout);
    check("enable idle", 128'h1, 128'(tdo_en_n));
  endtask

  task automatic check_id();
    check("id word", 128'({REV, PART, MFR, 1'b1}), 128'(dout[31:0]));
  endtask

  task automatic check_mode(input logic drv, input logic flt);
    repeat (8) @(posedge clk);
    check("ext drive", 128'(drv), 128'(ext_drive));
    check("float", 128'(flt), 128'(q_float));
  endtask

  task automatic new_ring();
    @(posedge clk);
    ring <= 108'({rnd(), rnd(), rnd(), rnd()});
  endtask

  task automatic check_bsr(input string what);
    check(what, 128'({oe, ring}), 128'(dout[108:0]));
  endtask

  always @(tdo or tdo_en_n)
    if (rstn === 1'b1) check("tdo edge", 128'h0, 128'(tck));

  // Whole run needs under ten thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      end_sim();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    fork
      host.tap_reset();
    join_none
    repeat (5) @(posedge clk);
    check("reset float", 128'h0, 128'(q_float));
    check("reset enable", 128'h1, 128'(tdo_en_n));
    rstn <= 1'b1;
    wait fork;
    host.tap_reset();
    scan(32, 1'b0);
    check_id();
    // Reserved codes are never sent; bypass is reloaded with fresh data instead
    repeat (4) begin
      load_ir(`SBST_OP_BYPASS);
      scan(8, 1'b0);
      check("bypass", 128'({din[6:0], 1'b0}), 128'(dout[7:0]));
    end
    load_ir(`SBST_OP_IDREAD);
    scan(32, 1'b1);
    check_id();
    load_ir(`SBST_OP_SAMPLE);
    repeat (3) begin
      new_ring();
      scan(LEN, 1'(rnd()));
      check_bsr("sample");
      oe = din[108];
      check_mode(1'b0, 1'b0);
      check("latch", 128'(din[107:0]), 128'(ext_data));
    end
    scan(LEN, 1'b1);
    oe = 1'b1;
    latch = din;
    load_ir(`SBST_OP_EXTEST);
    check_mode(1'b1, 1'b0);
    check("extest data", 128'(latch[107:0]), 128'(ext_data));
    new_ring();
    scan(LEN, 1'b0);
    check_bsr("extest capture");
    oe = 1'b0;
    check_mode(1'b1, 1'b1);
    @(posedge clk);
    ce <= 1'b0;
    load_ir(`SBST_OP_SAMPZ);
    repeat (8) @(posedge clk);
    check("frozen", 128'h1, 128'(ext_drive));
    @(posedge clk);
    ce <= 1'b1;
    check_mode(1'b0, 1'b1);
    new_ring();
    scan(LEN, 1'b0);
    check_bsr("sampz capture");
    check_mode(1'b0, 1'b1);
    host.tap_reset();
    oe = 1'b1;
    check_mode(1'b0, 1'b0);
    scan(32, 1'b0);
    check_id();
    load_ir(`SBST_OP_SAMPLE);
    new_ring();
    scan(LEN, 1'b0);
    check_bsr("preset enable");
    end_sim();
  end
endmodule // testbench
